// File: core/pdc_pkg.sv
// Package: offsets, field layout, reset values and carrier structs for the device block
package pdc_pkg;

  // Configuration offsets (byte addresses in configuration space)
  localparam logic [11:0] PDC_OFF_CAP_WORD = 12'h0a4;
  localparam logic [11:0] PDC_OFF_CTL_WORD = 12'h0a8;
  localparam logic [11:0] PDC_OFF_STS_WORD = 12'h0aa;

  // Capability word fields
  localparam int PDC_CAP_EXT_TAG_BIT = 5;
  localparam int PDC_CAP_PHANTOM_LSB = 3;
  localparam int PDC_CAP_MPS_LSB = 0;
  localparam logic [31:0] PDC_CAP_RESET = 32'h0000_0000;

  // Control word fields
  localparam int PDC_CTL_MPS_LSB = 5;
  localparam int PDC_CTL_UR_EN_BIT = 3;
  localparam int PDC_CTL_FATAL_EN_BIT = 2;
  localparam int PDC_CTL_NONFATAL_EN_BIT = 1;
  localparam int PDC_CTL_CORR_EN_BIT = 0;
  localparam logic [15:0] PDC_CTL_WMASK = 16'h00ef;
  localparam logic [15:0] PDC_CTL_RESET = 16'h0000;

  // Status word fields
  localparam int PDC_STS_PEND_BIT = 5;
  localparam int PDC_STS_UR_BIT = 3;
  localparam int PDC_STS_FATAL_BIT = 2;
  localparam int PDC_STS_NONFATAL_BIT = 1;
  localparam int PDC_STS_CORR_BIT = 0;
  localparam logic [3:0] PDC_STS_ERR_RESET = 4'h0;

  // Maximum payload encodings
  localparam logic [2:0] PDC_MPS_128 = 3'h0;
  localparam logic [12:0] PDC_MPS_128_BYTES = 13'h0080;

  // Error event bundle: index 3 UR, 2 fatal, 1 non-fatal, 0 correctable
  typedef struct packed {
    logic ur;
    logic fatal;
    logic nonfatal;
    logic corr;
  } pdc_err_t;

  // Configuration access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } pdc_cfg_req_t;

endpackage

// File: core/pdc_err_flags.sv
// Sticky write-one-to-clear detected-error flags
`timescale 1ns/10ps
`default_nettype none
module pdc_err_flags (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Events and clear
  input wire pdc_pkg::pdc_err_t detect,
  input wire pdc_pkg::pdc_err_t clear,
  // Flags
  output pdc_pkg::pdc_err_t flags
);
  import pdc_pkg::*;

  typedef struct packed {
    pdc_err_t flags;
  } pdc_ef_state_t;

  pdc_ef_state_t state;
  pdc_ef_state_t next_state;

  // Set beats clear; logged whatever the enables
  always_comb begin
    next_state = state;
    next_state.flags = (state.flags & ~clear) | detect;
  end

  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign flags = state.flags;
endmodule // pdc_err_flags
`default_nettype wire

// File: core/pdc_pend_track.sv
// Outstanding non-posted transaction counter
`timescale 1ns/10ps
`default_nettype none
module pdc_pend_track #(
  parameter int CNT_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Events
  input wire logic issue,
  input wire logic retire,
  // Status
  output logic pending
);
  import pdc_pkg::*;

  // Refuse counter widths the logic cannot serve
  if (CNT_W < 1 || CNT_W > 16) begin : g_bad_cnt_w
    $error("pdc_pend_track: CNT_W out of range");
  end

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic pending;
  } pdc_pt_state_t;

  pdc_pt_state_t state;
  pdc_pt_state_t next_state;

  // Count up on issue, down on retire, saturating
  always_comb begin
    next_state = state;
    if (issue && !retire && state.count != {CNT_W{1'b1}}) begin
      next_state.count = state.count + 1'b1;
    end else if (retire && !issue && state.count != '0) begin
      next_state.count = state.count - 1'b1;
    end
    next_state.pending = (next_state.count != '0);
  end

  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign pending = state.pending;
endmodule // pdc_pend_track
`default_nettype wire

// File: core/pdc_dev_regs.sv
// Device capability, control and status registers of the root port
`timescale 1ns/10ps
`default_nettype none
module pdc_dev_regs #(
  parameter int PEND_CNT_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Configuration access
  input wire pdc_pkg::pdc_cfg_req_t cfg_req,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  output logic cfg_hit,
  // Locally detected error events
  input wire pdc_pkg::pdc_err_t err_detect,
  // Non-posted transaction tracking
  input wire logic np_issue,
  input wire logic np_retire,
  // Transmit and receive payload limits
  input wire logic [12:0] tx_len_req,
  output logic [12:0] tx_len_max,
  output logic [12:0] rx_len_max,
  // Internal error reporting
  output pdc_pkg::pdc_err_t err_report
);
  import pdc_pkg::*;

  // Counter width the pending tracker can serve
  if (PEND_CNT_W < 1 || PEND_CNT_W > 16) begin : g_bad_pend_cnt_w
    $error("pdc_dev_regs: PEND_CNT_W out of range");
  end

  typedef struct packed {
    logic [15:0] ctl;
    logic [31:0] rdata;
    logic rvalid;
    logic [12:0] tx_len;
    pdc_err_t report;
  } pdc_dr_state_t;

  pdc_dr_state_t state;
  pdc_dr_state_t next_state;
  pdc_err_t flags;
  pdc_err_t clear;
  logic pending;
  logic sel_cap;
  logic sel_ctl;
  logic [31:0] cap_word;
  logic [15:0] sts_word;
  logic [15:0] ctl_wdata;
  logic [15:0] ctl_wmask_be;
  logic [12:0] mps_bytes;

  //////////////////////////////////////////////////////////////////////////////
  // Address decode: the dword at 0xa8 holds control (low) and status (high)
  assign sel_cap = (cfg_req.addr[11:2] == PDC_OFF_CAP_WORD[11:2]);
  assign sel_ctl = (cfg_req.addr[11:2] == PDC_OFF_CTL_WORD[11:2]);
  assign cfg_hit = sel_cap || sel_ctl;

  // Capability word: all fields fixed
  always_comb begin
    cap_word = PDC_CAP_RESET;
    cap_word[PDC_CAP_EXT_TAG_BIT] = 1'b0;
    cap_word[PDC_CAP_PHANTOM_LSB +: 2] = 2'h0;
    cap_word[PDC_CAP_MPS_LSB +: 3] = PDC_MPS_128;
  end

  // Status word image
  always_comb begin
    sts_word = 16'h0000;
    sts_word[PDC_STS_PEND_BIT] = pending;
    sts_word[PDC_STS_UR_BIT] = flags.ur;
    sts_word[PDC_STS_FATAL_BIT] = flags.fatal;
    sts_word[PDC_STS_NONFATAL_BIT] = flags.nonfatal;
    sts_word[PDC_STS_CORR_BIT] = flags.corr;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Byte-enabled control write data
  assign ctl_wmask_be = {{8{cfg_req.be[1]}}, {8{cfg_req.be[0]}}} & PDC_CTL_WMASK;
  assign ctl_wdata = cfg_req.wdata[15:0];

  // Status write-one-to-clear, upper half of the dword
  always_comb begin
    clear = '0;
    if (cfg_req.wr && sel_ctl && cfg_req.be[2]) begin
      clear.ur = cfg_req.wdata[16 + PDC_STS_UR_BIT];
      clear.fatal = cfg_req.wdata[16 + PDC_STS_FATAL_BIT];
      clear.nonfatal = cfg_req.wdata[16 + PDC_STS_NONFATAL_BIT];
      clear.corr = cfg_req.wdata[16 + PDC_STS_CORR_BIT];
    end
  end

  // Payload size in bytes from the setting; reserved codes fall back to 128
  always_comb begin
    unique case (state.ctl[PDC_CTL_MPS_LSB +: 3])
      PDC_MPS_128: mps_bytes = PDC_MPS_128_BYTES;
      default: mps_bytes = PDC_MPS_128_BYTES;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    next_state = state;
    next_state.rvalid = cfg_req.rd;
    // Control write, reserved bits held at zero
    if (cfg_req.wr && sel_ctl) begin
      next_state.ctl = (state.ctl & ~ctl_wmask_be) | (ctl_wdata & ctl_wmask_be);
    end
    // Read data; unmapped reads return zero
    if (cfg_req.rd) begin
      if (sel_cap) begin
        next_state.rdata = cap_word;
      end else if (sel_ctl) begin
        next_state.rdata = {sts_word, state.ctl};
      end else begin
        next_state.rdata = 32'h0000_0000;
      end
    end
    // Clamp transmit length to the set size
    next_state.tx_len = (tx_len_req > mps_bytes) ? mps_bytes : tx_len_req;
    // Internal reporting gated by enables; local events only
    next_state.report.ur = err_detect.ur && state.ctl[PDC_CTL_UR_EN_BIT];
    next_state.report.fatal = err_detect.fatal && state.ctl[PDC_CTL_FATAL_EN_BIT];
    next_state.report.nonfatal =
      err_detect.nonfatal && state.ctl[PDC_CTL_NONFATAL_EN_BIT];
    next_state.report.corr = err_detect.corr && state.ctl[PDC_CTL_CORR_EN_BIT];
  end

  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= '0;
      state.ctl <= PDC_CTL_RESET;
    end else begin
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sticky flags, logged regardless of enables
  pdc_err_flags u_flags (
    .clk(clk),
    .rstn(rstn),
    .detect(err_detect),
    .clear(clear),
    .flags(flags)
  );

  // Pending transaction tracking
  pdc_pend_track #(
    .CNT_W(PEND_CNT_W)
  ) u_pend (
    .clk(clk),
    .rstn(rstn),
    .issue(np_issue),
    .retire(np_retire),
    .pending(pending)
  );

  // Outputs
  assign cfg_rdata = state.rdata;
  assign cfg_rvalid = state.rvalid;
  assign tx_len_max = state.tx_len;
  assign rx_len_max = mps_bytes;
  assign err_report = state.report;
endmodule // pdc_dev_regs
`default_nettype wire

// File: sim/pdc_dev_regs_checker.sv
// Checker for device control and status
`timescale 1ns/10ps
`default_nettype none
module pdc_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Watched ports
  input wire pdc_pkg::pdc_cfg_req_t cfg_req,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rvalid,
  input wire logic cfg_hit,
  input wire pdc_pkg::pdc_err_t err_detect,
  input wire logic [12:0] tx_len_req,
  input wire logic [12:0] tx_len_max,
  input wire logic [12:0] rx_len_max,
  input wire pdc_pkg::pdc_err_t err_report
);
  import pdc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////
  // Event, then a status read next cycle
  sequence s_det_rd;
    (err_detect != 4'h0) ##1 (cfg_req.rd && cfg_req.addr[11:2] == 10'h2a);
  endsequence
  property p_rv; cfg_req.rd |=> cfg_rvalid; endproperty
  a_rv: assert property (p_rv) else $error("no rvalid");
  property p_norv; !cfg_req.rd |=> !cfg_rvalid; endproperty
  a_norv: assert property (p_norv) else $error("stray rvalid");
  property p_cap; cfg_req.rd && cfg_req.addr[11:2] == 10'h29 |=> cfg_rdata == 32'h0; endproperty
  a_cap: assert property (p_cap) else $error("cap nonzero");
  property p_rsv; cfg_rvalid |-> (cfg_rdata & 32'hffd0_ff10) == 32'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved set");
  property p_tx;
    1'b1 |=> tx_len_max == (($past(tx_len_req) > 13'h80) ? 13'h80 : $past(tx_len_req));
  endproperty
  a_tx: assert property (p_tx) else $error("tx too long");
  property p_rx; rx_len_max == 13'h80; endproperty
  a_rx: assert property (p_rx) else $error("rx size");
  property p_hit;
    cfg_hit == (cfg_req.addr[11:2] == 10'h29 || cfg_req.addr[11:2] == 10'h2a);
  endproperty
  a_hit: assert property (p_hit) else $error("decode hit");
  property p_rep; 1'b1 |=> (err_report & ~$past(err_detect)) == 4'h0; endproperty
  a_rep: assert property (p_rep) else $error("stray report");
  property p_flag;
    s_det_rd |=> (cfg_rdata[19:16] & $past(err_detect, 2)) == $past(err_detect, 2);
  endproperty
  a_flag: assert property (p_flag) else $error("flag lost");
endmodule // pdc_chk
bind pdc_dev_regs pdc_chk u_chk (.clk(clk), .rstn(rstn), .cfg_req(cfg_req),
  .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .cfg_hit(cfg_hit), .err_detect(err_detect),
  .tx_len_req(tx_len_req), .tx_len_max(tx_len_max), .rx_len_max(rx_len_max),
  .err_report(err_report));
`default_nettype wire

// File: sim/pdc_far.sv
// Far-side model returning completions
`timescale 1ns/10ps
`default_nettype none
module pdc_far (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Requests and pace
  input wire logic np_issue,
  input wire logic [3:0] lat,
  // Completions
  output logic np_retire
);
  int owed;
  int t;
  wire logic go = owed > 0 && t > int'(lat);
  // One completion each time the pace timer runs out
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      owed <= 0;
      t <= 0;
      np_retire <= 1'b0;
    end else begin
      np_retire <= go;
      owed <= owed + int'(np_issue) - int'(go);
      t <= (go || np_issue) ? 0 : t + 1;
    end
  end
endmodule // pdc_far
`default_nettype wire

// File: sim/test_pcie_root_port_device_ctl_sts.sv
// Bench for device control and status
`timescale 1ns/10ps
`default_nettype none
module test_pcie_root_port_device_ctl_sts;
  import pdc_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  pdc_cfg_req_t req = '0;
  pdc_err_t det_in = '0;
  logic issue = 1'b0;
  logic retire;
  logic [3:0] lat = 4'h0;
  logic [12:0] tx_req = 13'h0;
  logic [12:0] tx_max;
  logic [12:0] rx_max;
  logic [31:0] rdata;
  logic rvalid;
  pdc_err_t rep;
  logic [15:0] ctl = 16'h0;
  logic [3:0] fl = 4'h0;
  logic [31:0] s = 32'h840956f2;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  // Clock
  always #4 clk = ~clk;
  pdc_dev_regs dut (.clk(clk), .rstn(rstn), .cfg_req(req), .cfg_rdata(rdata),
    .cfg_rvalid(rvalid), .cfg_hit(), .err_detect(det_in), .np_issue(issue),
    .np_retire(retire), .tx_len_req(tx_req), .tx_len_max(tx_max), .rx_len_max(rx_max),
    .err_report(rep));
  pdc_far far (.clk(clk), .rstn(rstn), .np_issue(issue), .lat(lat), .np_retire(retire));
  ////////////////
  // Expectation helpers
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [31:0] sts(input logic p);
    return {10'h0, p, 1'b0, fl, ctl};
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Config write, with an optional event in the same cycle
  task wr(input logic [11:0] a, input logic [3:0] b, input logic [31:0] d, input logic [3:0] e);
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, b, d};
    det_in <= e;
    @(posedge clk);
    req.wr <= 1'b0;
    det_in <= 4'h0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x);
    @(posedge clk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk(rdata, x);
  endtask
  task det(input logic [3:0] e);
    @(posedge clk) det_in <= e;
    @(posedge clk) det_in <= 4'h0;
    fl = fl | e;
    #1 chk(32'(rep), 32'(e & ctl[3:0]));
  endtask
  task report_and_stop();
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      report_and_stop();
    end
  end
  ////////////////
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rd(12'h0a4, 32'h0);
    rd(12'h0a8, sts(1'b0));
    wr(12'h0a4, 4'hf, '1, 4'h0);
    rd(12'h0a4, 32'h0);
    rd(12'h010, 32'h0);
    for (int i = 0; i < 8; i++) begin
      s = lfsr(s);
      wr(12'h0a8, 4'h3, s, 4'h0);
      ctl = s[15:0] & 16'h00ef;
      rd(12'h0a8, sts(1'b0));
      @(posedge clk) tx_req <= 13'(s[23:16]);
    end
    wr(12'h0a8, 4'h1, 32'h0, 4'h0);
    ctl = 16'h0;
    det(4'hf);
    rd(12'h0a8, sts(1'b0));
    wr(12'h0a8, 4'h1, 32'hf, 4'h0);
    ctl = 16'h000f;
    for (int i = 0; i < 4; i++) det(4'h1 << i);
    wr(12'h0a8, 4'h4, 32'h0005_0000, 4'h0);
    fl = 4'ha;
    rd(12'h0a8, sts(1'b0));
    wr(12'h0a8, 4'h4, 32'h000f_0000, 4'h1);
    fl = 4'h1;
    rd(12'h0a8, sts(1'b0));
    // Detection followed by a status read on the very next edge
    @(posedge clk) det_in <= 4'h4;
    @(posedge clk) begin
      det_in <= 4'h0;
      req.rd <= 1'b1;
      req.addr <= 12'h0a8;
    end
    fl = 4'h5;
    @(posedge clk) req.rd <= 1'b0;
    #1 chk(rdata, sts(1'b0));
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) lat <= 4'(6 * i);
      @(posedge clk) issue <= 1'b1;
      @(posedge clk) issue <= 1'b0;
      rd(12'h0a8, sts(1'b1));
      repeat (12) @(posedge clk);
      rd(12'h0a8, sts(1'b0));
    end
    report_and_stop();
  end
endmodule // test_pcie_root_port_device_ctl_sts
`default_nettype wire
